// file: rtl/ccdsg_pkg.sv
// constants shared by the clock divide, select and gate block
package ccdsg_pkg;
   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_SELSRC = 5'h04;
   localparam logic [4:0] ADDR_TRUNK = 5'h08;
   localparam logic [4:0] ADDR_EDGE = 5'h0C;
   localparam logic [4:0] ADDR_STATUS = 5'h10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0080;
   localparam logic [31:0] SELSRC_RST = 32'h0000_0201;
   localparam logic [31:0] EDGE_RST = 32'h0403_0201;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int CTRL_RATIO_LSB = 0;
   localparam int CTRL_EMODE_LSB = 3;
   localparam int CTRL_SEL = 5;
   localparam int CTRL_GLITCHLESS = 6;
   localparam int CTRL_GATE = 7;
   localparam int CTRL_DIVPATH = 8;
   localparam int SELSRC_A_LSB = 0;
   localparam int SELSRC_B_LSB = 8;
   localparam int TRUNK_IDX_LSB = 0;
   localparam int TRUNK_DOM = 4;
   localparam int TRUNK_SRC_LSB = 8;
   localparam int STAT_LOCK = 9;
   localparam int STAT_ENA = 10;
   localparam int STAT_ENB = 11;
   // -------------------------------------------------------------
   // sizes and counts
   // -------------------------------------------------------------
   localparam int SRC_N = 64;
   localparam int SRC_W = 6;
   localparam int TRUNK_N = 16;
   localparam int TRUNK_W = 4;
   localparam int DOMAIN_N = 2;
   localparam int EDGE_N = 4;
   localparam int CODE_W = 9;
   localparam int PDIV_CNT_W = 7;
   localparam int PER_W = 11;
   localparam int DLY_DEPTH = 512;
   localparam int HALF_W = 4;
   typedef enum logic [1:0] {
      CCDSG_EDIV_2 = 2'h0,
      CCDSG_EDIV_3P5 = 2'h1,
      CCDSG_EDIV_4 = 2'h2,
      CCDSG_EDIV_5 = 2'h3
   } ccdsg_ediv_e;
endpackage

// file: rtl/ccdsg_top.sv
// clock dividers, glitchless selector, domain gate, center mux, delay-lock loop
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps

// Function
// R1 - primary divider ratios 2 to 128 in powers of two, plus bypass
// R2 - divider reset clears every divider output low at once, no clock
// R3 - reset release synchronous; output toggles from next input cycle
// R4 - edge divider by 2, 3.5, 4, 5; phase set by reset release
// R5 - center mux picks any of 64 sources for each of 16 trunks
// R6 - two primary domains, each carrying at most 16 clocks
// R7 - at most two center mux inputs pass through the selector
// R8 - one selector input optionally via primary divider, fed from input mux
// R9 - glitchless mode switches between two clocks without glitches
// R10 - glitchless use needs both selector clocks running
// R11 - disabled domain gate holds its clock at a constant level
// R12 - gate switching is glitchless and adds no latency
// R13 - delay-lock loop derives 9-bit quarter-period code for all slaves
// R14 - strobe delay buffer delays strobes by the distributed code
// R15 - slave clock delay shifts a primary clock by the code
// R16 - four separate edge clock networks
// R17 - selector syncs select per input clock, stops old clock low first
// R18 - gate enable taken while the clock is low
module ccdsg_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [ccdsg_pkg::SRC_N-1:0] src_clk_i,
   input wire logic pdiv_rst_i,
   input wire logic ediv_rst_i,
   input wire logic ref_clk_i,
   input wire logic strobe_i,
   input wire logic dly_clk_i,
   input wire logic [ccdsg_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [ccdsg_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic pdiv_clk_o,
   output logic ediv_clk_o,
   output logic sel_clk_o,
   output logic gate_clk_o,
   output logic [ccdsg_pkg::DOMAIN_N*ccdsg_pkg::TRUNK_N-1:0] trunk_clk_o,
   output logic [ccdsg_pkg::EDGE_N-1:0] edge_clk_o,
   output logic [ccdsg_pkg::CODE_W-1:0] dll_code_o,
   output logic dll_lock_o,
   output logic strobe_dly_o,
   output logic dly_clk_o
);
   // -------------------------------------------------------------
   // reset and input synchronisers
   // -------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic sys_rst_n;
   logic [ccdsg_pkg::SRC_N-1:0] src_s1_r, src_s2_r;
   logic [2:0] misc_s1_r, misc_s2_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign sys_rst_n = rst_sync_r[1];

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         src_s1_r <= '0;
         src_s2_r <= '0;
         misc_s1_r <= 3'h0;
         misc_s2_r <= 3'h0;
      end else begin
         src_s1_r <= src_clk_i;
         src_s2_r <= src_s1_r;
         misc_s1_r <= {dly_clk_i, strobe_i, ref_clk_i};
         misc_s2_r <= misc_s1_r;
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [31:0] ctrl_r, selsrc_r, edge_r, trunk_last_r;
   logic [ccdsg_pkg::SRC_W-1:0] trunk_sel_r [ccdsg_pkg::DOMAIN_N][ccdsg_pkg::TRUNK_N];
   logic [ccdsg_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_have_r, w_have_r;
   logic ena_r, enb_r;
   logic [ccdsg_pkg::CODE_W-1:0] code_r;
   logic lock_r;

   function automatic logic mapped(input logic [ccdsg_pkg::ADDR_W-1:0] a);
      logic [4:0] w;
      w = {a[4:2], 2'b00};
      return w == ccdsg_pkg::ADDR_CTRL || w == ccdsg_pkg::ADDR_SELSRC ||
             w == ccdsg_pkg::ADDR_TRUNK || w == ccdsg_pkg::ADDR_EDGE ||
             w == ccdsg_pkg::ADDR_STATUS;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i+:8] = d[8*i+:8];
         end
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // axi4-lite write channel
   // -------------------------------------------------------------
   logic [31:0] trunk_w;
   logic [4:0] waddr_w;
   assign waddr_w = {awaddr_r[4:2], 2'b00};
   assign trunk_w = merge(trunk_last_r, wdata_r, wstrb_r);

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= ccdsg_pkg::RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         ctrl_r <= ccdsg_pkg::CTRL_RST;
         selsrc_r <= ccdsg_pkg::SELSRC_RST;
         edge_r <= ccdsg_pkg::EDGE_RST;
         trunk_last_r <= 32'h0;
         trunk_sel_r <= '{default: '{default: '0}};
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            awaddr_r <= s_axi_awaddr_i;
            aw_have_r <= 1'b1;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
            w_have_r <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end
         if (aw_have_r && w_have_r && !s_axi_bvalid_o) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= mapped(awaddr_r) ? ccdsg_pkg::RESP_OKAY : ccdsg_pkg::RESP_SLVERR;
            if (waddr_w == ccdsg_pkg::ADDR_CTRL) begin
               ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_01FF;
            end
            if (waddr_w == ccdsg_pkg::ADDR_SELSRC) begin
               selsrc_r <= merge(selsrc_r, wdata_r, wstrb_r) & 32'h0000_3F3F;
            end
            if (waddr_w == ccdsg_pkg::ADDR_EDGE) begin
               edge_r <= merge(edge_r, wdata_r, wstrb_r) & 32'h3F3F_3F3F;
            end
            if (waddr_w == ccdsg_pkg::ADDR_TRUNK) begin
               trunk_last_r <= trunk_w & 32'h0000_3F1F;
               trunk_sel_r[trunk_w[ccdsg_pkg::TRUNK_DOM]]
                  [trunk_w[ccdsg_pkg::TRUNK_IDX_LSB+:ccdsg_pkg::TRUNK_W]]
                  <= trunk_w[ccdsg_pkg::TRUNK_SRC_LSB+:ccdsg_pkg::SRC_W]; // R5 R6
            end
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // axi4-lite read channel
   // -------------------------------------------------------------
   logic [4:0] raddr_w;
   logic [31:0] rdata_nxt;
   assign raddr_w = {s_axi_araddr_i[4:2], 2'b00};

   always_comb begin
      rdata_nxt = 32'h0;
      unique case (raddr_w)
         ccdsg_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
         ccdsg_pkg::ADDR_SELSRC: rdata_nxt = selsrc_r;
         ccdsg_pkg::ADDR_TRUNK: rdata_nxt = trunk_last_r;
         ccdsg_pkg::ADDR_EDGE: rdata_nxt = edge_r;
         ccdsg_pkg::ADDR_STATUS: rdata_nxt = {20'h0, enb_r, ena_r, lock_r, code_r};
         default: rdata_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0;
         s_axi_rresp_o <= ccdsg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rdata_nxt;
         s_axi_rresp_o <= mapped(s_axi_araddr_i) ? ccdsg_pkg::RESP_OKAY : ccdsg_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // primary divider
   // -------------------------------------------------------------
   logic pdiv_arst_n, ediv_arst_n;
   logic [1:0] pdiv_rel_r, ediv_rel_r;
   logic b_direct, b_in, a_in, a_q_r, b_q_r, pdiv_in_q_r;
   logic [ccdsg_pkg::PDIV_CNT_W-1:0] pdiv_cnt_r;
   logic [2:0] ratio;
   // pin clears at once; release is retimed
   assign pdiv_arst_n = sys_rst_n & ~pdiv_rst_i; // R2
   assign ediv_arst_n = sys_rst_n & ~ediv_rst_i; // R2
   assign ratio = ctrl_r[ccdsg_pkg::CTRL_RATIO_LSB+:3];
   assign a_in = src_s2_r[selsrc_r[ccdsg_pkg::SELSRC_A_LSB+:ccdsg_pkg::SRC_W]];
   assign b_direct = src_s2_r[selsrc_r[ccdsg_pkg::SELSRC_B_LSB+:ccdsg_pkg::SRC_W]];
   assign b_in = ctrl_r[ccdsg_pkg::CTRL_DIVPATH] ? pdiv_clk_o : b_direct; // R8

   always_ff @(posedge clk_i or negedge pdiv_arst_n) begin
      if (!pdiv_arst_n) begin
         pdiv_rel_r <= 2'h0;
         pdiv_cnt_r <= '0;
         pdiv_in_q_r <= 1'b0;
         pdiv_clk_o <= 1'b0; // R2
      end else begin
         pdiv_rel_r <= {pdiv_rel_r[0], 1'b1}; // R3
         pdiv_in_q_r <= b_direct; // R8
         if (!pdiv_rel_r[1]) begin
            pdiv_clk_o <= 1'b0;
         end else if (ratio == 3'h0) begin
            pdiv_clk_o <= b_direct; // R1
         end else if (b_direct && !pdiv_in_q_r) begin
            pdiv_cnt_r <= pdiv_cnt_r + 7'h01;
            pdiv_clk_o <= pdiv_cnt_r_next_bit(pdiv_cnt_r, ratio); // R1 R3
         end
      end
   end

   function automatic logic pdiv_cnt_r_next_bit(input logic [6:0] c, input logic [2:0] r);
      logic [6:0] n;
      n = c + 7'h01;
      return n[r - 3'h1];
   endfunction

   // -------------------------------------------------------------
   // edge clock networks and edge divider
   // -------------------------------------------------------------
   logic [ccdsg_pkg::HALF_W-1:0] half_r, halves, half_nxt;
   logic ediv_in_q_r;
   ccdsg_pkg::ccdsg_ediv_e emode;
   assign emode = ccdsg_pkg::ccdsg_ediv_e'(ctrl_r[ccdsg_pkg::CTRL_EMODE_LSB+:2]);

   for (genvar k = 0; k < ccdsg_pkg::EDGE_N; k++) begin : g_edge
      always_ff @(posedge clk_i or negedge sys_rst_n) begin
         if (!sys_rst_n) begin
            edge_clk_o[k] <= 1'b0;
         end else begin
            edge_clk_o[k] <= src_s2_r[edge_r[8*k+:ccdsg_pkg::SRC_W]]; // R16
         end
      end
   end

   always_comb begin
      unique case (emode)
         ccdsg_pkg::CCDSG_EDIV_2: halves = 4'h4;
         ccdsg_pkg::CCDSG_EDIV_3P5: halves = 4'h7;
         ccdsg_pkg::CCDSG_EDIV_4: halves = 4'h8;
         ccdsg_pkg::CCDSG_EDIV_5: halves = 4'hA;
      endcase
      half_nxt = (half_r >= halves - 4'h1) ? 4'h0 : half_r + 4'h1;
   end

   // both input edges counted, so 3.5 needs no second clock
   always_ff @(posedge clk_i or negedge ediv_arst_n) begin
      if (!ediv_arst_n) begin
         ediv_rel_r <= 2'h0;
         half_r <= '0;
         ediv_in_q_r <= 1'b0;
         ediv_clk_o <= 1'b0; // R2
      end else begin
         ediv_rel_r <= {ediv_rel_r[0], 1'b1}; // R3
         ediv_in_q_r <= edge_clk_o[0];
         if (!ediv_rel_r[1]) begin
            half_r <= '0; // R4
            ediv_clk_o <= 1'b0;
         end else if (edge_clk_o[0] != ediv_in_q_r) begin
            half_r <= half_nxt;
            ediv_clk_o <= half_nxt < ((halves + 4'h1) >> 1); // R4
         end
      end
   end

   // -------------------------------------------------------------
   // dynamic clock selector and domain gate
   // -------------------------------------------------------------
   logic ena_s_r, enb_s_r, sel, sel_nxt, gate_en_r;
   assign sel = ctrl_r[ccdsg_pkg::CTRL_SEL];
   // a stopped input clock freezes the glitchless handover
   always_comb begin
      if (ctrl_r[ccdsg_pkg::CTRL_GLITCHLESS]) begin
         sel_nxt = (a_in & ena_r) | (b_in & enb_r); // R9 R10
      end else begin
         sel_nxt = sel ? b_in : a_in; // R10
      end
   end

   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         a_q_r <= 1'b0;
         b_q_r <= 1'b0;
         ena_s_r <= 1'b0;
         ena_r <= 1'b0;
         enb_s_r <= 1'b0;
         enb_r <= 1'b0;
      end else begin
         a_q_r <= a_in;
         b_q_r <= b_in;
         if (a_q_r && !a_in) begin
            ena_s_r <= !sel && !enb_r; // R17
            ena_r <= ena_s_r && !sel; // R17
         end
         if (b_q_r && !b_in) begin
            enb_s_r <= sel && !ena_r; // R17
            enb_r <= enb_s_r && sel; // R17
         end
      end
   end

   // shared output stage: gating adds no latency
   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         gate_en_r <= 1'b0;
         sel_clk_o <= 1'b0;
         gate_clk_o <= 1'b0;
      end else begin
         sel_clk_o <= sel_nxt;
         if (!sel_nxt) begin
            gate_en_r <= ctrl_r[ccdsg_pkg::CTRL_GATE]; // R18
         end
         gate_clk_o <= sel_nxt & (sel_nxt ? gate_en_r : 1'b0); // R11 R12
      end
   end

   // -------------------------------------------------------------
   // center mux trunks
   // -------------------------------------------------------------
   logic [ccdsg_pkg::SRC_N-1:0] cm_src;
   // source 0 is the gated selector path
   assign cm_src = {src_s2_r[ccdsg_pkg::SRC_N-1:1], gate_clk_o}; // R7

   for (genvar d = 0; d < ccdsg_pkg::DOMAIN_N; d++) begin : g_dom
      for (genvar t = 0; t < ccdsg_pkg::TRUNK_N; t++) begin : g_trunk
         always_ff @(posedge clk_i or negedge sys_rst_n) begin
            if (!sys_rst_n) begin
               trunk_clk_o[d*ccdsg_pkg::TRUNK_N+t] <= 1'b0;
            end else begin
               trunk_clk_o[d*ccdsg_pkg::TRUNK_N+t] <= cm_src[trunk_sel_r[d][t]]; // R5 R6
            end
         end
      end
   end

   // -------------------------------------------------------------
   // delay-lock loop and slave delays
   // -------------------------------------------------------------
   logic [ccdsg_pkg::PER_W-1:0] per_r;
   logic ref_q_r;
   logic [1:0] dly_in;
   logic [1:0] dly_out_r;
   assign dly_in = {misc_s2_r[2], misc_s2_r[1]};

   // code unit is one clk_i period; slow references saturate
   always_ff @(posedge clk_i or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         ref_q_r <= 1'b0;
         per_r <= '0;
         code_r <= '0;
         lock_r <= 1'b0;
      end else begin
         ref_q_r <= misc_s2_r[0];
         if (misc_s2_r[0] && !ref_q_r) begin
            per_r <= 11'h001;
            code_r <= per_r[ccdsg_pkg::PER_W-1:2]; // R13
            lock_r <= per_r[ccdsg_pkg::PER_W-1:2] == code_r;
         end else if (per_r != 11'h7FF) begin
            per_r <= per_r + 11'h001;
         end
      end
   end
   assign dll_code_o = code_r; // R13
   assign dll_lock_o = lock_r;

   for (genvar j = 0; j < 2; j++) begin : g_dly
      logic [ccdsg_pkg::DLY_DEPTH-1:0] line_r;
      always_ff @(posedge clk_i or negedge sys_rst_n) begin
         if (!sys_rst_n) begin
            line_r <= '0;
            dly_out_r[j] <= 1'b0;
         end else begin
            line_r <= {line_r[ccdsg_pkg::DLY_DEPTH-2:0], dly_in[j]};
            dly_out_r[j] <= line_r[code_r]; // R14 R15
         end
      end
   end
   assign strobe_dly_o = dly_out_r[0];
   assign dly_clk_o = dly_out_r[1];
endmodule

// file: tb/ccdsg_chk.sv
// assertions on the clock block's top ports
`timescale 1ns/10ps
module ccdsg_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pdiv_rst_i,
   input wire logic ediv_rst_i,
   input wire logic [ccdsg_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic strobe_i,
   input wire logic dly_clk_i,
   input wire logic pdiv_clk_o,
   input wire logic ediv_clk_o,
   input wire logic sel_clk_o,
   input wire logic gate_clk_o,
   input wire logic [ccdsg_pkg::CODE_W-1:0] dll_code_o,
   input wire logic dll_lock_o,
   input wire logic strobe_dly_o,
   input wire logic dly_clk_o
);
   logic gate_en_r;
   logic glitch_r;
   logic [5:0] hold_r;
   logic ctrl_wr;
   // shadow of gate and glitchless bits
   assign ctrl_wr = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      && s_axi_awaddr_i == ccdsg_pkg::ADDR_CTRL && s_axi_wstrb_i[0];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_en_r <= 1'b1;
         hold_r <= 6'h00;
      end else if (ctrl_wr && s_axi_wdata_i[7] != gate_en_r) begin
         gate_en_r <= s_axi_wdata_i[7];
         hold_r <= 6'h00;
      end else if (hold_r != 6'h3F) begin
         hold_r <= hold_r + 6'h01;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         glitch_r <= 1'b0;
      end else if (ctrl_wr) begin
         glitch_r <= s_axi_wdata_i[6];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_hi2;
      sel_clk_o [*2];
   endsequence
   sequence s_lo2;
      !sel_clk_o [*2];
   endsequence
   sequence s_code8;
      dll_lock_o && $past(dll_lock_o, 16) && dll_code_o == 9'h008
         && $past(dll_code_o, 16) == 9'h008;
   endsequence
   a_pdiv_rst_low: assert property (pdiv_rst_i |-> !pdiv_clk_o)
      else $error("primary divider high in reset");
   a_ediv_rst_low: assert property (ediv_rst_i |-> !ediv_clk_o)
      else $error("edge divider high in reset");
   a_pdiv_restart: assert property ($fell(pdiv_rst_i) |-> !pdiv_clk_o [*2])
      else $error("primary divider restarted early");
   a_sel_high_min: assert property (glitch_r && $rose(sel_clk_o) |=> s_hi2)
      else $error("short selector high pulse");
   a_sel_low_min: assert property (glitch_r && $fell(sel_clk_o) |=> s_lo2)
      else $error("short selector low pulse");
   a_gate_frozen: assert property (!gate_en_r && hold_r > 6'h28 |-> $stable(gate_clk_o))
      else $error("gated clock toggles when off");
   a_gate_same: assert property (gate_en_r && hold_r > 6'h28 |-> gate_clk_o == sel_clk_o)
      else $error("gated clock differs from selector");
   a_gate_edge: assert property ($changed(gate_clk_o) |-> gate_clk_o == sel_clk_o)
      else $error("gated clock moved off selector edge");
   a_strobe_delay: assert property (s_code8 |-> strobe_dly_o == $past(strobe_i, 12))
      else $error("strobe delay not code plus sync");
   a_dly_shift: assert property (s_code8 |-> dly_clk_o == $past(dly_clk_i, 12))
      else $error("shifted clock not code plus sync");
endmodule

// file: tb/ccdsg_src_model.sv
// free-running sources standing in for the fabric side
`timescale 1ns/10ps
module ccdsg_src_model (
   output logic [63:0] src_clk_o,
   output logic ref_clk_o,
   output logic strobe_o,
   output logic dly_clk_o
);
   logic [7:0] cnt_r = 8'h00;
   // 13 ns offset keeps edges off the system clock
   initial begin
      #13;
      forever begin
         #40;
         cnt_r = cnt_r + 8'h01;
      end
   end
   // all sources run, selected or not
   for (genvar i = 0; i < 64; i++) begin : g_src
      assign src_clk_o[i] = cnt_r[2 + i % 3];
   end
   assign ref_clk_o = cnt_r[4];
   assign strobe_o = cnt_r[5];
   assign dly_clk_o = cnt_r[3];
endmodule

// file: tb/ccdsg_top_bench.sv
// self-checking bench for the clock block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module ccdsg_top_bench;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] div_rst = 2'b00;
   logic pdiv_rst_i, ediv_rst_i, ref_clk_i, strobe_i, dly_clk_i;
   logic [63:0] src_clk_i;
   logic [4:0] s_axi_awaddr_i = 5'h00;
   logic [4:0] s_axi_araddr_i = 5'h00;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0] s_axi_wstrb_i = 4'hF;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_rdata_o, trunk_clk_o;
   logic pdiv_clk_o, ediv_clk_o, sel_clk_o, gate_clk_o, dll_lock_o, strobe_dly_o, dly_clk_o;
   logic [3:0] edge_clk_o;
   logic [8:0] dll_code_o;
   logic [39:0] obs;
   int err_count = 0;
   int check_count = 0;
   int edge_p[4] = '{16, 32, 8, 16};
   int ediv_p[4] = '{32, 56, 64, 80};
   logic [31:0] sel_c[5] = '{32'hC0, 32'hE0, 32'h1C1, 32'h1E1, 32'hA0};
   int sel_p[5] = '{16, 32, 0, 64, 32};
   assign pdiv_rst_i = div_rst[0];
   assign ediv_rst_i = div_rst[1];
   assign obs = {trunk_clk_o, edge_clk_o, gate_clk_o, sel_clk_o, ediv_clk_o, pdiv_clk_o};
   ccdsg_src_model i_ccdsg_src_model (.src_clk_o(src_clk_i), .ref_clk_o(ref_clk_i),
      .strobe_o(strobe_i), .dly_clk_o(dly_clk_i));
   ccdsg_top i_ccdsg_top (.*);
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // bus and measurement tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      r = s_axi_bresp_o;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
   endtask
   // the first periods may be partial, so the third is timed
   task automatic per(input int o, output int p);
      time t0;
      repeat (2) begin
         wait (obs[o] === 1'b0);
         wait (obs[o] === 1'b1);
      end
      t0 = $time;
      wait (obs[o] === 1'b0);
      wait (obs[o] === 1'b1);
      p = int'(($time - t0) / 40);
   endtask
   task automatic rst_chk(input int o, input int ex);
      int p;
      wait (obs[o] === 1'b1);
      @(posedge clk_i);
      div_rst[o] <= 1'b1;
      #1;
      `CHK("divider cleared", 1'b0, obs[o])
      repeat (8) @(posedge clk_i);
      div_rst[o] <= 1'b0;
      per(o, p);
      `CHK("divider restart", ex, p)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int p;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(ccdsg_pkg::ADDR_CTRL, d, r);
      `CHK("ctrl reset", ccdsg_pkg::CTRL_RST, d)
      rd(ccdsg_pkg::ADDR_SELSRC, d, r);
      `CHK("selsrc reset", ccdsg_pkg::SELSRC_RST, d)
      rd(ccdsg_pkg::ADDR_EDGE, d, r);
      `CHK("edge reset", ccdsg_pkg::EDGE_RST, d)
      rd(5'h14, d, r);
      `CHK("unmapped read resp", ccdsg_pkg::RESP_SLVERR, r)
      `CHK("unmapped read data", 32'h0, d)
      wr(5'h18, 32'hFFFF_FFFF, r);
      `CHK("unmapped write resp", ccdsg_pkg::RESP_SLVERR, r)
      wr(ccdsg_pkg::ADDR_STATUS, 32'hFFFF_FFFF, r);
      `CHK("status write resp", ccdsg_pkg::RESP_OKAY, r)
      $display("test registers done");
      wr(ccdsg_pkg::ADDR_TRUNK, 32'h3E1F, r);
      rd(ccdsg_pkg::ADDR_TRUNK, d, r);
      `CHK("trunk entry", 32'h3E1F, d)
      per(39, p);
      `CHK("trunk 31 period", 32, p)
      wr(ccdsg_pkg::ADDR_TRUNK, 32'h0300, r);
      per(8, p);
      `CHK("trunk 0 period", 8, p)
      for (int k = 0; k < 4; k++) begin
         per(4 + k, p);
         `CHK("edge net period", edge_p[k], p)
      end
      $display("test trunks done");
      for (int n = 0; n < 8; n++) begin
         wr(ccdsg_pkg::ADDR_CTRL, 32'h80 | n, r);
         per(0, p);
         `CHK("primary divider period", 32 << n, p)
      end
      wr(ccdsg_pkg::ADDR_CTRL, 32'h81, r);
      rst_chk(0, 64);
      for (int m = 0; m < 4; m++) begin
         wr(ccdsg_pkg::ADDR_CTRL, 32'h80 | (m << 3), r);
         per(1, p);
         `CHK("edge divider period", ediv_p[m], p)
      end
      rst_chk(1, 80);
      $display("test dividers done");
      for (int s = 0; s < 5; s++) begin
         wr(ccdsg_pkg::ADDR_CTRL, sel_c[s], r);
         if (sel_p[s] != 0) begin
            per(2, p);
            `CHK("selector period", sel_p[s], p)
         end
      end
      wr(ccdsg_pkg::ADDR_CTRL, 32'h20, r);
      repeat (40) @(posedge clk_i);
      repeat (64) begin
         @(posedge clk_i);
         `CHK("gate held low", 1'b0, gate_clk_o)
      end
      wr(ccdsg_pkg::ADDR_CTRL, 32'hA0, r);
      per(3, p);
      `CHK("gate period", 32, p)
      $display("test selector and gate done");
      rd(ccdsg_pkg::ADDR_STATUS, d, r);
      `CHK("status lock and code", 10'h208, d[9:0])
      `CHK("code port", 9'h008, dll_code_o)
      $display("test delay loop done");
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      $display("watchdog expired");
      report_and_stop();
   end
endmodule
bind ccdsg_top ccdsg_chk i_ccdsg_chk (.*);
